// File: design/oft_defines.vh
// Purpose: Shared constants of the overlap flashover trip logic.
// Assumes: Included by bare name; definitions only.
// Notes: Register byte offsets, field positions, reset values, timing.
`ifndef OFT_DEFINES_VH
`define OFT_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFT_ADDR_CTRL 12'h000
`define OFT_ADDR_THRESH 12'h004
`define OFT_ADDR_STATUS 12'h008
`define OFT_ADDR_INT_STAT 12'h00C
`define OFT_ADDR_INT_MASK 12'h010

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define OFT_CTRL_EN_BIT 0
`define OFT_LEVEL_W 16
`define OFT_NUM_PT 4
`define OFT_NUM_CONTACT 7
`define OFT_NUM_IRQ 4
`define OFT_ST_LIVE_LSB 0
`define OFT_ST_CONTACT_LSB 8
`define OFT_ST_NORMAL_BIT 16
`define OFT_ST_EXTENDED_BIT 17
`define OFT_ST_DISABLED_BIT 18
`define OFT_ST_TRIP_BIT 19
`define OFT_ST_INHIBIT_BIT 20
`define OFT_IRQ_TRIP 0
`define OFT_IRQ_RELEASE 1
`define OFT_IRQ_DIS_ON 2
`define OFT_IRQ_DIS_OFF 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OFT_CTRL_RST 1'b1
`define OFT_THRESH_RST 16'h4000
`define OFT_MASK_RST 4'h0
`define OFT_ZERO_WORD 32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OFT_CLK_PERIOD_PS 4000
`define OFT_SAMPLE_PERIOD_NS 1000
`define OFT_SAMPLE_CYCLES ((`OFT_SAMPLE_PERIOD_NS * 1000) / `OFT_CLK_PERIOD_PS)
`define OFT_DEB_SAMPLES 4

`endif

// File: design/oft_trip_logic.v
// Purpose: Trip decision logic guarding an insulated overlap between
//          two catenary sections, with an APB register slave.
// Assumes: All inputs synchronous to pclk; one clock of 250 MHz.
// Notes: Level samples arrive with a one-cycle valid strobe.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "oft_defines.vh"

// What this block does
// - Watch all four levels and every contact
// - Section dead when its level falls low
// - Tripped breaker yet live section flags bridging
// - Bridging trips both feeder breakers
// - Inhibit reclose with trip until pantograph leaves
// - Normal feed: breakers, interruptors closed, bridge open
// - Breaker A feeds 1,2; breaker B feeds 3,4
// - Extended feed disables protection and trips
// - Closed bridging interruptor also disables protection
// - Show disabled indication while condition lasts
module oft_trip_logic (
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Level samples of the four transformers
  input wire [15:0] level_pt_1,
  input wire [15:0] level_pt_2,
  input wire [15:0] level_pt_3,
  input wire [15:0] level_pt_4,
  input wire level_valid,
  // Auxiliary contacts, high means closed
  input wire feeder_breaker_a_closed,
  input wire feeder_breaker_b_closed,
  input wire line_interruptor_1_closed,
  input wire line_interruptor_2_closed,
  input wire line_interruptor_3_closed,
  input wire line_interruptor_4_closed,
  input wire bridging_interruptor_closed,
  // Commands and indications
  output reg trip_feeder_breaker_a,
  output reg trip_feeder_breaker_b,
  output reg reclose_inhibit,
  output reg protection_disabled,
  output wire irq
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  // Alarm state machine codes
  localparam ST_IDLE = 1'b0;
  localparam ST_ALARM = 1'b1;
  // Last count of the sample divider
  localparam integer DIV_LAST_I = `OFT_SAMPLE_CYCLES - 1;
  localparam [7:0] DIV_LAST = DIV_LAST_I[7:0];
  // Last count of the debounce counter
  localparam integer DEB_LAST_I = `OFT_DEB_SAMPLES - 1;
  localparam [2:0] DEB_LAST = DEB_LAST_I[2:0];

  // ----------------------------------------------------------------
  // Register file storage
  // ----------------------------------------------------------------
  reg ctrl_en_reg; // Protection enable
  reg [15:0] thresh_reg; // Live/dead threshold
  reg [3:0] int_stat_reg; // Sticky event flags
  reg [3:0] int_mask_reg; // Interrupt enables

  // ----------------------------------------------------------------
  // Sampling and filtering state
  // ----------------------------------------------------------------
  reg [7:0] div_reg; // Sample tick divider
  reg tick_reg; // One-cycle sample enable
  reg [3:0] live_pt_reg; // Per-transformer live flags
  wire [6:0] contact_raw; // Raw contact vector
  wire [6:0] contact_flt; // Debounced contact vector
  wire [63:0] level_vec; // All four levels packed

  // ----------------------------------------------------------------
  // Decision state
  // ----------------------------------------------------------------
  reg state_reg; // Alarm machine state
  reg [1:0] side_reg; // Sections found bridged
  reg dis_prev_reg; // Disabled flag one cycle ago
  reg [3:0] event_pulse; // Events of this cycle

  // Named views of the filtered contacts
  wire fb_a = contact_flt[0];
  wire fb_b = contact_flt[1];
  wire li_1 = contact_flt[2];
  wire li_2 = contact_flt[3];
  wire li_3 = contact_flt[4];
  wire li_4 = contact_flt[5];
  wire bridge = contact_flt[6];

  // ----------------------------------------------------------------
  // Input gathering
  // ----------------------------------------------------------------
  // Contacts are read only on sample ticks, levels only on valid strobes
  assign contact_raw = {bridging_interruptor_closed,
                        line_interruptor_4_closed,
                        line_interruptor_3_closed,
                        line_interruptor_2_closed,
                        line_interruptor_1_closed,
                        feeder_breaker_b_closed,
                        feeder_breaker_a_closed};
  assign level_vec = {level_pt_4, level_pt_3, level_pt_2, level_pt_1};

  // ----------------------------------------------------------------
  // Sample tick divider
  // ----------------------------------------------------------------
  // Slow enable that paces contact sampling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_LAST) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Contact debounce, one filter per contact
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `OFT_NUM_CONTACT; gi = gi + 1) begin : g_deb
      reg [2:0] cnt_reg; // Consecutive differing samples
      reg flt_reg; // Accepted contact state
      // Accept a change only after it holds for several ticks
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg <= 3'h0;
          flt_reg <= 1'b0;
        end else if (tick_reg) begin
          if (contact_raw[gi] == flt_reg) begin
            // Stable: restart the count
            cnt_reg <= 3'h0;
          end else if (cnt_reg == DEB_LAST) begin
            // Held long enough: take it
            flt_reg <= contact_raw[gi];
            cnt_reg <= 3'h0;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
      end
      assign contact_flt[gi] = flt_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Level comparison, one per transformer
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < `OFT_NUM_PT; gi = gi + 1) begin : g_lvl
      // Each sample checked against the threshold setting
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          live_pt_reg[gi] <= 1'b0;
        end else if (level_valid) begin
          live_pt_reg[gi] <=
            (level_vec[gi*16 +: 16] >= thresh_reg);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Feed conditions
  // ----------------------------------------------------------------
  // Section A through interruptors 1,2; B through 3,4
  wire live_a = live_pt_reg[0] | live_pt_reg[1];
  wire live_b = live_pt_reg[2] | live_pt_reg[3];
  // Normal feed pattern
  wire normal_feed = fb_a & fb_b & li_1 & li_2 & li_3 & li_4 & ~bridge;
  // Any line interruptor open means feed is extended
  wire extended_feed = ~(li_1 & li_2 & li_3 & li_4);
  // Closed bridge or extended feed disables protection
  wire disabled_now = extended_feed | bridge;
  wire armed = ctrl_en_reg & ~disabled_now;
  // Tripped breaker while its section still reads live
  wire flash_a = armed & ~fb_a & live_a;
  wire flash_b = armed & ~fb_b & live_b;
  // Pantograph gone once every flagged section reads dead
  wire panto_left = ~((side_reg[0] & live_a) | (side_reg[1] & live_b));

  // ----------------------------------------------------------------
  // Alarm state machine
  // ----------------------------------------------------------------
  // Raises trips and reclose inhibit, holds inhibit until clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      side_reg <= 2'b00;
      trip_feeder_breaker_a <= 1'b0;
      trip_feeder_breaker_b <= 1'b0;
      reclose_inhibit <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (flash_a | flash_b) begin
            // Trip both breakers together with the inhibit
            state_reg <= ST_ALARM;
            side_reg <= {flash_b, flash_a};
            trip_feeder_breaker_a <= 1'b1;
            trip_feeder_breaker_b <= 1'b1;
            reclose_inhibit <= 1'b1;
          end
        end
        ST_ALARM: begin
          if (!armed | panto_left) begin
            // Disabled or overlap clear: drop all
            state_reg <= ST_IDLE;
            side_reg <= 2'b00;
            trip_feeder_breaker_a <= 1'b0;
            trip_feeder_breaker_b <= 1'b0;
            reclose_inhibit <= 1'b0;
          end else begin
            // Keep tripping while bridging persists
            side_reg <= side_reg | {flash_b, flash_a};
            trip_feeder_breaker_a <= 1'b1;
            trip_feeder_breaker_b <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Disabled indication
  // ----------------------------------------------------------------
  // Level output follows the disabled condition
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_disabled <= 1'b0;
      dis_prev_reg <= 1'b0;
    end else begin
      protection_disabled <= disabled_now;
      dis_prev_reg <= protection_disabled;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // One-cycle pulses feeding the sticky status
  always @* begin
    event_pulse = 4'h0;
    event_pulse[`OFT_IRQ_TRIP] = (state_reg == ST_IDLE) &
                                 (flash_a | flash_b);
    event_pulse[`OFT_IRQ_RELEASE] = (state_reg == ST_ALARM) &
                                    (~armed | panto_left);
    event_pulse[`OFT_IRQ_DIS_ON] = protection_disabled & ~dis_prev_reg;
    event_pulse[`OFT_IRQ_DIS_OFF] = ~protection_disabled & dis_prev_reg;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in one access cycle
  assign pready = 1'b1;
  wire setup_ph = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire hit_ctrl = (paddr == `OFT_ADDR_CTRL);
  wire hit_thresh = (paddr == `OFT_ADDR_THRESH);
  wire hit_status = (paddr == `OFT_ADDR_STATUS);
  wire hit_stat = (paddr == `OFT_ADDR_INT_STAT);
  wire hit_mask = (paddr == `OFT_ADDR_INT_MASK);
  wire hit_any = hit_ctrl | hit_thresh | hit_status | hit_stat |
                   hit_mask;

  // Live state image for software
  wire [31:0] status_word = {11'h000,
                        reclose_inhibit,
                        trip_feeder_breaker_a,
                        protection_disabled,
                        extended_feed,
                        normal_feed,
                        1'b0,
                        contact_flt,
                        4'h0,
                        live_pt_reg};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control, threshold and mask storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_reg <= `OFT_CTRL_RST;
      thresh_reg <= `OFT_THRESH_RST;
      int_mask_reg <= `OFT_MASK_RST;
    end else if (wr_acc) begin
      if (hit_ctrl) begin
        ctrl_en_reg <= pwdata[`OFT_CTRL_EN_BIT];
      end
      if (hit_thresh) begin
        thresh_reg <= pwdata[15:0];
      end
      if (hit_mask) begin
        int_mask_reg <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky interrupt status
  // ----------------------------------------------------------------
  // Write one to clear; a new event wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= 4'h0;
    end else if (wr_acc & hit_stat) begin
      int_stat_reg <= (int_stat_reg & ~pwdata[3:0]) | event_pulse;
    end else begin
      int_stat_reg <= int_stat_reg | event_pulse;
    end
  end

  // Level interrupt while any unmasked flag is set
  assign irq = |(int_stat_reg & int_mask_reg);

  // ----------------------------------------------------------------
  // Read data and error
  // ----------------------------------------------------------------
  // Captured in the setup cycle, held through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `OFT_ZERO_WORD;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= ~hit_any;
      if (pwrite) begin
        prdata <= `OFT_ZERO_WORD;
      end else if (hit_ctrl) begin
        prdata <= {31'h0000_0000, ctrl_en_reg};
      end else if (hit_thresh) begin
        prdata <= {16'h0000, thresh_reg};
      end else if (hit_status) begin
        prdata <= status_word;
      end else if (hit_stat) begin
        prdata <= {28'h000_0000, int_stat_reg};
      end else if (hit_mask) begin
        prdata <= {28'h000_0000, int_mask_reg};
      end else begin
        // Unmapped address reads zero
        prdata <= `OFT_ZERO_WORD;
      end
    end
  end

endmodule

// File: tb/oft_trip_checker.sv
// Purpose: Port-level assertions for the overlap trip logic.
// Assumes: One clock, asynchronous active-low reset.
// Notes: 1300 cycles covers four 250-cycle debounce ticks plus margin.
`timescale 1ns/1ps
module oft_trip_checker (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic [11:0] paddr,
  input logic pslverr,
  input logic line_interruptor_1_closed,
  input logic line_interruptor_2_closed,
  input logic line_interruptor_3_closed,
  input logic line_interruptor_4_closed,
  input logic bridging_interruptor_closed,
  input logic trip_feeder_breaker_a,
  input logic trip_feeder_breaker_b,
  input logic reclose_inhibit,
  input logic protection_disabled
);
  localparam int LIM = 1300;
  logic [10:0] cnt_br; // Cycles bridge held closed
  logic [10:0] cnt_li; // Cycles some line interruptor held open
  logic [10:0] cnt_ok; // Cycles line interruptors closed and bridge open
  wire li_all = line_interruptor_1_closed & line_interruptor_2_closed &
    line_interruptor_3_closed & line_interruptor_4_closed;
  wire unmapped = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C,
    12'h010});
  // Saturating count that restarts whenever the condition drops
  function automatic [10:0] sat_inc(input [10:0] c, input logic go);
    if (!go)
      return 11'h000;
    return (c < LIM) ? c + 11'h001 : c;
  endfunction
  // -----------------------------------------------------------------
  // Contact hold counters
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_br <= 11'h000;
      cnt_li <= 11'h000;
      cnt_ok <= 11'h000;
    end else begin
      cnt_br <= sat_inc(cnt_br, bridging_interruptor_closed);
      cnt_li <= sat_inc(cnt_li, !li_all);
      cnt_ok <= sat_inc(cnt_ok, li_all & !bridging_interruptor_closed);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  a_trip_both_sides: assert property (
    trip_feeder_breaker_a == trip_feeder_breaker_b)
    else $error("feeder trips differ");
  a_inhibit_with_trip: assert property (
    $rose(trip_feeder_breaker_a) |-> $rose(reclose_inhibit))
    else $error("inhibit not raised with trip");
  a_release_joint: assert property (
    $fell(reclose_inhibit) |-> $fell(trip_feeder_breaker_a))
    else $error("inhibit released apart from trip");
  a_disabled_no_trip: assert property (
    protection_disabled |-> !trip_feeder_breaker_a && !reclose_inhibit)
    else $error("trip while disabled");
  a_bridge_disables: assert property (
    cnt_br == LIM |-> protection_disabled)
    else $error("closed bridge not disabling");
  a_extended_disables: assert property (
    cnt_li == LIM |-> protection_disabled)
    else $error("open line interruptor not disabling");
  a_normal_enabled: assert property (
    cnt_ok == LIM |-> !protection_disabled)
    else $error("disabled in normal feed");
  a_unmapped_error: assert property (
    psel && !penable |=> pslverr == $past(unmapped))
    else $error("slave error decode wrong");
endmodule
bind oft_trip_logic oft_trip_checker i_oft_trip_checker (.pclk, .presetn,
  .psel, .penable, .paddr, .pslverr, .line_interruptor_1_closed,
  .line_interruptor_2_closed, .line_interruptor_3_closed,
  .line_interruptor_4_closed, .bridging_interruptor_closed,
  .trip_feeder_breaker_a, .trip_feeder_breaker_b, .reclose_inhibit,
  .protection_disabled);

// File: tb/oft_partner_model.sv
// Purpose: Breakers, interruptors and auto-reclose seen by the relay.
// Assumes: want bits {bridge, li4..li1, fb_b, fb_a}, high = closed.
// Notes: A tripped breaker stays open while reclose is inhibited.
`timescale 1ns/1ps
module oft_partner_model (
  input logic pclk,
  input logic presetn,
  input logic trip_a,
  input logic trip_b,
  input logic inhibit,
  input logic [6:0] want,
  output logic [6:0] contact_closed
);
  // Breaker trips open; reclose only once the inhibit is gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contact_closed <= 7'h3F;
    end else begin
      contact_closed[6:2] <= want[6:2];
      if (trip_a || !want[0])
        contact_closed[0] <= 1'b0;
      else if (!inhibit)
        contact_closed[0] <= 1'b1;
      if (trip_b || !want[1])
        contact_closed[1] <= 1'b0;
      else if (!inhibit)
        contact_closed[1] <= 1'b1;
    end
  end
endmodule

// File: tb/test_oft_trip_logic.sv
// Purpose: Self-checking bench for the overlap trip logic.
// Assumes: Contacts settle within 1400 cycles of debounce.
// Notes: Each scenario is its own task.
`timescale 1ns/1ps
`include "oft_defines.vh"
module test_oft_trip_logic;
  localparam int SETTLE = 1400;
  logic pclk, presetn, psel, penable, pwrite, level_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] lv1, lv2, lv3, lv4;
  logic [6:0] want;
  wire [31:0] prdata;
  wire pready, pslverr, irq, trip_a, trip_b, inhibit, dis;
  wire [6:0] cc;
  int num_errors, n_compared;
  oft_trip_logic i_oft_trip_logic (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_pt_1(lv1), .level_pt_2(lv2), .level_pt_3(lv3),
    .level_pt_4(lv4), .level_valid(level_valid),
    .feeder_breaker_a_closed(cc[0]), .feeder_breaker_b_closed(cc[1]),
    .line_interruptor_1_closed(cc[2]), .line_interruptor_2_closed(cc[3]),
    .line_interruptor_3_closed(cc[4]), .line_interruptor_4_closed(cc[5]),
    .bridging_interruptor_closed(cc[6]), .trip_feeder_breaker_a(trip_a),
    .trip_feeder_breaker_b(trip_b), .reclose_inhibit(inhibit),
    .protection_disabled(dis), .irq(irq));
  oft_partner_model i_oft_partner_model (.pclk(pclk), .presetn(presetn),
    .trip_a(trip_a), .trip_b(trip_b), .inhibit(inhibit), .want(want),
    .contact_closed(cc));
  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task check(input string what, input [31:0] exp, input [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task apb(input logic wr, input [11:0] a, input [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input string w, input [11:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(w, exp, rd);
  endtask
  // Level sample strobe, then wait until trips would have moved
  task pulse(input [15:0] a, input [15:0] b, input [15:0] c,
    input [15:0] d);
    @(posedge pclk);
    lv1 <= a;
    lv2 <= b;
    lv3 <= c;
    lv4 <= d;
    level_valid <= 1'b1;
    @(posedge pclk);
    level_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task outs(input string w, input [2:0] exp);
    check(w, {29'h0, exp}, {29'h0, trip_a, trip_b, inhibit});
  endtask
  // New contact states, then let debounce settle
  task set_want(input [6:0] w);
    @(posedge pclk);
    want <= w;
    repeat (SETTLE) @(posedge pclk);
    #1;
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task t_reset;
    rd_chk("ctrl", `OFT_ADDR_CTRL, 32'h0000_0001);
    rd_chk("thresh", `OFT_ADDR_THRESH, 32'h0000_4000);
    rd_chk("mask", `OFT_ADDR_INT_MASK, 32'h0000_0000);
    check("disabled at start", 32'h1, {31'h0, dis});
    apb(1'b0, 12'h014, 32'h0000_0000);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
  endtask
  task t_normal;
    set_want(7'h3F);
    check("normal enabled", 32'h0, {31'h0, dis});
    rd_chk("status", `OFT_ADDR_STATUS, 32'h0001_3F00);
    check("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, `OFT_ADDR_INT_STAT, 32'h0000_000F);
    apb(1'b1, `OFT_ADDR_INT_MASK, 32'h0000_0001);
  endtask
  task t_trip;
    set_want(7'h3E);
    pulse(16'h0000, 16'h0000, 16'h5000, 16'h5000);
    outs("closed side live", 3'b000);
    apb(1'b1, `OFT_ADDR_CTRL, 32'h0000_0000);
    pulse(16'h5000, 16'h0000, 16'h0000, 16'h0000);
    outs("enable off", 3'b000);
    apb(1'b1, `OFT_ADDR_CTRL, 32'h0000_0001);
    pulse(16'h5000, 16'h0000, 16'h0000, 16'h0000);
    outs("bridged trip", 3'b111);
    check("irq", 32'h1, {31'h0, irq});
    rd_chk("status trip", `OFT_ADDR_STATUS, 32'h0018_3E01);
    pulse(16'h0000, 16'h5000, 16'h0000, 16'h0000);
    outs("still bridged", 3'b111);
    pulse(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    outs("section dead", 3'b000);
    rd_chk("int stat", `OFT_ADDR_INT_STAT, 32'h0000_0003);
    apb(1'b1, `OFT_ADDR_INT_STAT, 32'h0000_0003);
    #1;
    check("irq cleared", 32'h0, {31'h0, irq});
    set_want(7'h3F);
  endtask
  task t_thresh;
    set_want(7'h3D);
    apb(1'b1, `OFT_ADDR_THRESH, 32'h0000_1234);
    pulse(16'h0000, 16'h0000, 16'h0000, 16'h1233);
    outs("below thresh", 3'b000);
    pulse(16'h0000, 16'h0000, 16'h0000, 16'h1234);
    outs("at thresh", 3'b111);
    pulse(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    set_want(7'h3F);
  endtask
  // Disabling contact set: bridge closed or line interruptor open
  task t_disable(input [6:0] w);
    set_want(w);
    check("disabled", 32'h1, {31'h0, dis});
    pulse(16'h5000, 16'h5000, 16'h0000, 16'h0000);
    outs("no trip disabled", 3'b000);
    pulse(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    set_want(7'h3F);
    check("enabled again", 32'h0, {31'h0, dis});
  endtask
  task t_bounce;
    logic hit;
    hit = 1'b0;
    @(posedge pclk);
    want <= 7'h3B;
    repeat (600) @(posedge pclk);
    want <= 7'h3F;
    repeat (SETTLE) begin
      @(posedge pclk);
      hit = hit | dis;
    end
    check("bounce ignored", 32'h0, {31'h0, hit});
  endtask
  // -----------------------------------------------------------------
  // Main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, level_valid, presetn} = 5'h00;
    {paddr, pwdata, rd, err} = '0;
    {lv1, lv2, lv3, lv4} = '0;
    want = 7'h3F;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_normal();
    t_trip();
    t_thresh();
    t_disable(7'h7E);
    t_disable(7'h2E);
    t_bounce();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end
endmodule
